// File: hdl/rtec_gapdec.sv
// Purpose: fast-write gap interval decoder
// Assumes: gap is already synchronised; fce marks one field clock
// Notes:   intervals are measured from gap edge to gap edge
`timescale 1ns/1ps
`default_nettype none
`include "rtec_cfg.svh"
module rtec_gapdec import rtec_pkg::*; (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fce,
    input  wire logic gap,
    input  wire logic enable,
    output logic      bit_stb,
    output logic      bit_val,
    output logic      err_stb,
    output logic      active
);
    rtec_dec_t q;
    rtec_dec_t d;
    logic      rise;
    logic      fall;
    assign rise = gap && !q.gap_d;
    assign fall = !gap && q.gap_d;
    always_comb begin
        d = q;
        d.gap_d = gap;
        d.bit_stb = 1'b0;
        d.err_stb = 1'b0;
        if (fce && q.cnt != 6'h3F) begin
            d.cnt = q.cnt + 6'h01;
        end
        case (q.st)
            DEC_IDLE: begin
                d.active = 1'b0;
                if (rise) begin
                    d.st = DEC_SGAP;
                    d.cnt = 6'h00;
                end
            end
            DEC_SGAP: if (fall) begin
                d.cnt = 6'h00;
                d.active = q.cnt >= `RTEC_SGAP_MIN && q.cnt <= `RTEC_SGAP_MAX;
                d.st = d.active ? DEC_DATA : DEC_IDLE;
            end
            DEC_DATA: begin
                if (rise) begin
                    d.st = DEC_WGAP;
                    d.cnt = 6'h00;
                    d.bit_val = q.cnt >= `RTEC_D1_MIN;
                    d.bit_stb = (q.cnt >= `RTEC_D0_MIN && q.cnt <= `RTEC_D0_MAX) ||
                                (q.cnt >= `RTEC_D1_MIN && q.cnt <= `RTEC_D1_MAX);
                    d.err_stb = !d.bit_stb;
                end else if (q.cnt > `RTEC_FW_TOUT) begin
                    d.st = DEC_IDLE;
                    d.active = 1'b0;
                end
            end
            DEC_WGAP: if (fall) begin
                d.cnt = 6'h00;
                if (q.cnt >= `RTEC_FGAP_MIN && q.cnt <= `RTEC_FGAP_MAX) begin
                    d.st = DEC_DATA;
                end else begin
                    d.st = DEC_IDLE;
                    d.active = 1'b0;
                    d.err_stb = 1'b1;
                end
            end
            default: d.st = DEC_IDLE;
        endcase
        if (!enable) begin
            d.st = DEC_IDLE;
            d.active = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign bit_stb = q.bit_stb;
    assign bit_val = q.bit_val;
    assign err_stb = q.err_stb;
    assign active  = q.active;
endmodule : rtec_gapdec
`default_nettype wire

// File: hdl/rtec_top.sv
// Purpose: extended-mode configuration, bit-rate, encoder and fast-write
//          decoder of a passive identification tag, behind an APB slave
// Assumes: field clock and gap detector arrive as pins, sampled on pclk
// Notes:   all APB accesses answer after one wait state
`timescale 1ns/1ps
`default_nettype none
`include "rtec_cfg.svh"
module rtec_top import rtec_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        field_clk_pin,
    input  wire logic        gap_pin,
    output logic             damping_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rtec_top_t  q;
    rtec_top_t  d;
    logic       fce;
    logic [3:0] key;
    logic       ext_on;
    logic       test_ok;
    logic       write_lock;
    logic       cfg_frozen;
    logic       cfg_wr_ok;
    logic       inv_eff;
    logic       sst_eff;
    logic       fast_eff;
    logic [5:0] rate;
    logic [7:0] per;
    logic [7:0] half;
    logic [4:0] mode;
    logic [3:0] sc_per;
    logic       subc;
    logic       de;
    logic       mid_flip;
    logic       rd_acc;
    logic       wr_acc;
    logic [31:0] status;
    logic       dec_bit_stb;
    logic       dec_bit_val;
    logic       dec_err_stb;
    logic       dec_active;

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    assign key  = q.cfg[`RTEC_KEY_HI:`RTEC_KEY_LO];
    assign mode = q.cfg[`RTEC_MOD_HI:`RTEC_MOD_LO];

    // Only the two key codes open extended mode
    assign ext_on = q.cfg[`RTEC_XMODE] &&
                    (key == `RTEC_KEY_TEST || key == `RTEC_KEY_LOCK);

    assign test_ok    = key != `RTEC_KEY_LOCK;
    assign write_lock = q.cfg[`RTEC_OTP];
    assign cfg_frozen = q.cfg[`RTEC_OTP] && key == `RTEC_KEY_LOCK;

    // Once locked, only a test-mode request under key 9 may rewrite
    assign cfg_wr_ok = !q.cfg[`RTEC_OTP] ||
                       (q.test_req && key == `RTEC_KEY_TEST);

    assign inv_eff  = ext_on && q.cfg[`RTEC_INV];
    assign sst_eff  = ext_on && q.cfg[`RTEC_SST];
    assign fast_eff = ext_on && q.cfg[`RTEC_FAST];

    // Without extended mode the binary rate field is ignored
    assign rate = ext_on ? q.cfg[`RTEC_RATE_HI:`RTEC_RATE_LO] : `RTEC_RATE_STD;
    assign per  = {1'b0, rate, 1'b0} + 8'h02;
    assign half = {2'b00, rate} + 8'h01;

    // ------------------------------------------------------------
    // Field clock enable
    // ------------------------------------------------------------
    assign fce = q.fclk_s2 && !q.fclk_d;

    // ------------------------------------------------------------
    // Encoder data and subcarrier
    // ------------------------------------------------------------
    assign de = q.sh[33] ^ inv_eff;

    always_comb begin
        case (mode)
            `RTEC_M_PHASE_SHIFT_ON_CHANGE, `RTEC_M_PHASE_SHIFT_ON_HIGH, `RTEC_M_PHASE_SHIFT_ON_RISE: begin
                case (q.cfg[`RTEC_PCF_HI:`RTEC_PCF_LO])
                    2'h0:    sc_per = 4'h2;
                    2'h1:    sc_per = 4'h4;
                    default: sc_per = 4'h8;
                endcase
            end
            `RTEC_M_FREQ_SHIFT_FIVE_EIGHT: sc_per = de ? 4'h8 : 4'h5;
            `RTEC_M_FREQ_SHIFT_TEN_EIGHT: sc_per = de ? 4'h8 : 4'hA;
            default:      sc_per = 4'h2;
        endcase
    end

    // Odd periods give a slightly longer low half
    assign subc = q.sc < {1'b0, sc_per[3:1]};

    assign mid_flip = (mode == `RTEC_M_BI1) ? de :
                      (mode == `RTEC_M_BI2) ? !de : 1'b0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    assign rd_acc = psel && penable && !q.pready && !pwrite;
    assign wr_acc = psel && penable && q.pready && pwrite;

    assign status = {17'h00000, cfg_frozen, write_lock, test_ok, ext_on,
                     (q.tx_st == TX_RUN), dec_active, q.rx_err, 2'h0, q.rx_cnt};

    // ------------------------------------------------------------
    // Fast-write decoder
    // ------------------------------------------------------------
    rtec_gapdec u_gapdec (
        .pclk    (pclk),
        .presetn (presetn),
        .fce     (fce),
        .gap     (q.gap_s2),
        .enable  (fast_eff),
        .bit_stb (dec_bit_stb),
        .bit_val (dec_bit_val),
        .err_stb (dec_err_stb),
        .active  (dec_active)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.fclk_s1 = field_clk_pin;
        d.fclk_s2 = q.fclk_s1;
        d.fclk_d  = q.fclk_s2;
        d.gap_s1  = gap_pin;
        d.gap_s2  = q.gap_s1;

        // Bus answer: one wait state, data and error registered
        d.pready  = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            case (paddr)
                `RTEC_A_CFG, `RTEC_A_CTRL, `RTEC_A_TXD,
                `RTEC_A_STAT, `RTEC_A_RXD: d.pslverr = 1'b0;
                default: d.pslverr = 1'b1;
            endcase
        end
        if (rd_acc) begin
            case (paddr)
                `RTEC_A_CFG:  d.prdata = q.cfg;
                `RTEC_A_CTRL: d.prdata = {30'h00000000, q.test_req && test_ok, 1'b0};
                `RTEC_A_TXD:  d.prdata = q.tx_word;
                `RTEC_A_STAT: d.prdata = status;
                `RTEC_A_RXD:  d.prdata = q.rxd;
                default:      d.prdata = 32'h00000000;
            endcase
        end

        // Writes land on the edge where the master sees pready
        if (wr_acc) begin
            case (paddr)
                `RTEC_A_CFG: begin
                    if (cfg_wr_ok) begin
                        d.cfg = pwdata;
                    end
                end
                `RTEC_A_TXD: d.tx_word = pwdata;
                `RTEC_A_CTRL: begin
                    // Test access is ignored under key 6
                    d.test_req = pwdata[`RTEC_C_TEST] && test_ok;
                    if (pwdata[`RTEC_C_CLR]) begin
                        d.rx_cnt = 6'h00;
                        d.rx_err = 1'b0;
                        d.rxd    = 32'h00000000;
                    end
                    if (pwdata[`RTEC_C_START] && q.tx_st == TX_IDLE) begin
                        d.tx_st  = TX_RUN;
                        d.cnt    = 8'h00;
                        d.sc     = 4'h0;
                        d.bp_lvl = 1'b0;
                        d.psk_ph = 1'b0;
                        d.prev_de = inv_eff;
                        if (sst_eff) begin
                            d.sh    = {q.hdr, !q.hdr, q.tx_word};
                            d.nbits = 6'h22;
                            d.hdr   = !q.hdr;
                        end else begin
                            d.sh    = {q.tx_word, 2'h0};
                            d.nbits = 6'h20;
                        end
                    end
                end
                default: d.rx_err = q.rx_err;
            endcase
        end

        // Decoded write bits; a new event beats a same-cycle clear, except a bit arriving while the count is at 32
        if (dec_bit_stb && q.rx_cnt != 6'h20) begin
            d.rxd    = {d.rxd[30:0], dec_bit_val};
            d.rx_cnt = d.rx_cnt + 6'h01;
        end
        if (dec_err_stb) begin
            d.rx_err = 1'b1;
        end

        // Encoder, advanced once per field clock
        if (q.tx_st == TX_RUN && fce) begin
            if ({4'h0, q.sc} >= {4'h0, sc_per} - 8'h01) begin
                d.sc = 4'h0;
            end else begin
                d.sc = q.sc + 4'h1;
            end

            // Bit-start events
            if (q.cnt == 8'h00) begin
                case (mode)
                    `RTEC_M_PHASE_SHIFT_ON_CHANGE: begin
                        if (de != q.prev_de) begin
                            d.psk_ph = !q.psk_ph;
                        end
                    end
                    `RTEC_M_PHASE_SHIFT_ON_HIGH: begin
                        if (de) begin
                            d.psk_ph = !q.psk_ph;
                        end
                    end
                    `RTEC_M_PHASE_SHIFT_ON_RISE: begin
                        if (de && !q.prev_de) begin
                            d.psk_ph = !q.psk_ph;
                        end
                    end
                    `RTEC_M_BI1, `RTEC_M_BI2: d.bp_lvl = !q.bp_lvl;
                    default: d.psk_ph = q.psk_ph;
                endcase
            end
            if (q.cnt == half && mid_flip) begin
                d.bp_lvl = !q.bp_lvl;
            end

            // Damping level for this field clock
            case (mode)
                `RTEC_M_PHASE_SHIFT_ON_CHANGE, `RTEC_M_PHASE_SHIFT_ON_HIGH, `RTEC_M_PHASE_SHIFT_ON_RISE: d.damp = subc ^ d.psk_ph;
                `RTEC_M_FREQ_SHIFT_FIVE_EIGHT, `RTEC_M_FREQ_SHIFT_TEN_EIGHT: d.damp = subc;
                `RTEC_M_MANCH: d.damp = (q.cnt < half) ? !de : de;
                `RTEC_M_BI1, `RTEC_M_BI2: d.damp = d.bp_lvl;
                default: d.damp = de;
            endcase

            // Bit boundary
            if (q.cnt == per - 8'h01) begin
                d.cnt     = 8'h00;
                d.prev_de = de;
                d.sh      = {q.sh[32:0], 1'b0};
                d.nbits   = q.nbits - 6'h01;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end

        // Idle one field clock late so the last bit keeps its full length
        if (q.tx_st == TX_RUN && fce && q.nbits == 6'h00) begin
            d.tx_st = TX_IDLE;
            d.damp  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q     <= '0;
            q.cfg <= `RTEC_CFG_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata      = q.prdata;
    assign pready      = q.pready;
    assign pslverr     = q.pslverr;
    assign damping_out = q.damp;

endmodule : rtec_top
`default_nettype wire

// File: inc/rtec_cfg.svh
// Purpose: constants of the tag extended-mode codec
// Assumes: configuration bit k (1..32) sits at register bit 32-k
// Notes:   included by both design files, rtec_gapdec and rtec_top, not by the package
// Behaviour
// - Extended mode needs key 6 or 9 plus flag
// - Key 9 allows test access; key 6 refuses
// - Other keys keep extended options off
// - Extended-mode flag is configuration bit 15
// - Extended bit period is 2n+2 field clocks
// - One-time bit write-protects all memory blocks; the code guards only the configuration register
// - One-time bit with key 6 freezes configuration
// - One-time bit with key 9 allows test reconfiguration
// - First FSK: 0 at RF/5, 1 at RF/8
// - Second FSK: 0 at RF/10, 1 at RF/8
// - First PSK flips phase on data change
// - Second PSK flips phase per high bit
// - Third PSK flips phase on rising data
// - Manchester: 0 falls, 1 rises mid-bit
// - Biphase adds mid-bit change for one value
// - NRZ damps for 1, not for 0
// - Inverse option complements data for every encoding
// - Header flag sends two-bit start marker
// - Start marker inverts on every new sequence
// - Fast write: 12 clocks zero, 27 one
// - Fast write ends after 32 idle clocks
`ifndef RTEC_CFG_SVH
`define RTEC_CFG_SVH
`define RTEC_KEY_HI    31
`define RTEC_KEY_LO    28
`define RTEC_RATE_HI   23
`define RTEC_RATE_LO   18
`define RTEC_XMODE     17
`define RTEC_MOD_HI    16
`define RTEC_MOD_LO    12
`define RTEC_PCF_HI    11
`define RTEC_PCF_LO    10
`define RTEC_OTP       8
`define RTEC_SST       3
`define RTEC_FAST      2
`define RTEC_INV       1
`define RTEC_KEY_TEST  4'h9
`define RTEC_KEY_LOCK  4'h6
`define RTEC_CFG_RST   32'h00000000
`define RTEC_RATE_STD  6'h1F
`define RTEC_M_DIRECT  5'h00
`define RTEC_M_PHASE_SHIFT_ON_CHANGE    5'h01
`define RTEC_M_PHASE_SHIFT_ON_HIGH    5'h02
`define RTEC_M_PHASE_SHIFT_ON_RISE    5'h03
`define RTEC_M_FREQ_SHIFT_FIVE_EIGHT    5'h04
`define RTEC_M_FREQ_SHIFT_TEN_EIGHT    5'h05
`define RTEC_M_MANCH   5'h08
`define RTEC_M_BI1     5'h10
`define RTEC_M_BI2     5'h18
`define RTEC_A_CFG     8'h00
`define RTEC_A_CTRL    8'h04
`define RTEC_A_TXD     8'h08
`define RTEC_A_STAT    8'h0C
`define RTEC_A_RXD     8'h10
`define RTEC_C_START   0
`define RTEC_C_TEST    1
`define RTEC_C_CLR     2
`define RTEC_SGAP_MIN  6'h0A
`define RTEC_SGAP_MAX  6'h32
`define RTEC_FGAP_MIN  6'h08
`define RTEC_FGAP_MAX  6'h14
`define RTEC_D0_MIN    6'h08
`define RTEC_D0_MAX    6'h0F
`define RTEC_D1_MIN    6'h18
`define RTEC_D1_MAX    6'h1F
`define RTEC_FW_TOUT   6'h20
`endif

// File: inc/rtec_pkg.sv
// Purpose: state types of the tag extended-mode codec
// Assumes: constants come from rtec_cfg.svh
// Notes:   one packed struct holds each module's state
package rtec_pkg;
    typedef enum logic [1:0] {DEC_IDLE, DEC_SGAP, DEC_DATA, DEC_WGAP} rtec_dec_st_t;
    typedef enum logic {TX_IDLE, TX_RUN} rtec_tx_st_t;
    typedef struct packed {
        rtec_dec_st_t st;
        logic [5:0]   cnt;
        logic         gap_d;
        logic         bit_stb;
        logic         bit_val;
        logic         err_stb;
        logic         active;
    } rtec_dec_t;
    typedef struct packed {
        logic        fclk_s1;
        logic        fclk_s2;
        logic        fclk_d;
        logic        gap_s1;
        logic        gap_s2;
        logic [31:0] cfg;
        logic        test_req;
        logic [31:0] tx_word;
        rtec_tx_st_t tx_st;
        logic [33:0] sh;
        logic [5:0]  nbits;
        logic [7:0]  cnt;
        logic [3:0]  sc;
        logic        prev_de;
        logic        psk_ph;
        logic        bp_lvl;
        logic        hdr;
        logic        damp;
        logic [31:0] rxd;
        logic [5:0]  rx_cnt;
        logic        rx_err;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rtec_top_t;
endpackage : rtec_pkg

// File: tb/rtec_reader.sv
// Purpose: reader model, free-running field clock and gap-coded writes
// Assumes: field clock is pclk divided by ten
// Notes:   carrier never stops, also during gaps
`timescale 1ns/1ps
`default_nettype none
module rtec_reader (
    input  wire logic pclk,
    output logic      field_clk,
    output logic      gap
);
    logic [3:0] ph;
    initial begin
        ph = 4'h0;
        field_clk = 1'b0;
        gap = 1'b0;
    end
    always @(posedge pclk) begin
        ph        <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
        field_clk <= (ph < 4'h5);
    end
    task automatic wait_fc(input int n);
        repeat (n) @(posedge field_clk);
    endtask : wait_fc
    // Width t1 far from 27, outside the one window, lets a bench break it on purpose
    task automatic send(input logic [31:0] b, input int n, input int t1);
        int i;
        gap <= 1'b1;
        wait_fc(20);
        for (i = n - 1; i >= 0; i--) begin
            gap <= 1'b0;
            wait_fc(b[i] ? t1 : 12);
            gap <= 1'b1;
            wait_fc(10);
        end
        gap <= 1'b0;
    endtask : send
endmodule : rtec_reader
`default_nettype wire

// File: tb/rtec_top_sva.sv
// Purpose: port-level checker of the tag codec top
// Assumes: one clock domain, presetn asynchronous active low
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rtec_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        field_clk_pin,
    input wire logic        gap_pin,
    input wire logic        damping_out
);
    logic       fclk_q;
    logic [3:0] since;
    // ----------------------------------------
    // Field clock age, saturating at 15
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fclk_q <= 1'b0;
            since  <= 4'hF;
        end else begin
            fclk_q <= field_clk_pin;
            if (field_clk_pin && !fclk_q) since <= 4'h0;
            else if (since != 4'hF) since <= since + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_lat; psel && $rose(penable) |=> pready; endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("pready not one cycle after access");
    property p_ready_phase; pready |-> psel && penable; endproperty
    a_ready_phase: assert property (p_ready_phase) else $error("pready outside access phase");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_err_map;
        pready |-> (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}));
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr does not match map");
    property p_err_rdata; pready && pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
    a_err_rdata: assert property (p_err_rdata) else $error("refused read data not zero");
    property p_rdata_hold; !(psel && penable && !pwrite) |=> $stable(prdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    // Damping may only move shortly after a field clock rise
    property p_damp_fce; $changed(damping_out) |-> since <= 4'h6; endproperty
    a_damp_fce: assert property (p_damp_fce) else $error("damping moved off field clock");
    c_write: cover property (pready && pwrite);
    c_err: cover property (pready && pslverr);
    c_damp: cover property ($rose(damping_out));
endmodule : rtec_top_sva
bind rtec_top rtec_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .field_clk_pin(field_clk_pin), .gap_pin(gap_pin), .damping_out(damping_out));
`default_nettype wire

// File: tb/rtec_top_test.sv
// Purpose: self-checking bench of the tag codec top
// Assumes: APB answers after one wait state; rate field 1 gives 4 field clocks a bit
// Notes:   damping is sampled once per field clock, well after it settles
`timescale 1ns/1ps
`default_nettype none
module rtec_top_test;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rtec_note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fclk, gap, damping_out, x, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, w, c;
    int          n_errors, cmp_count, n_high, n_smp, f_hi, seed, k;
    rtec_note_t  notes[$];
    rtec_note_t  nt;
    rtec_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_clk_pin(fclk), .gap_pin(gap), .damping_out(damping_out));
    rtec_reader rdr (.pclk(pclk), .field_clk(fclk), .gap(gap));
    always #2.5 pclk = ~pclk;
    task automatic fail(input string s);
        n_errors++;
        $display("ERROR %0t %s", $time, s);
    endtask : fail
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // Answer watcher and damping sampler
    // ----------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) fail("answer without request");
            else begin
                nt = notes.pop_front();
                cmp_count++;
                if (pslverr !== nt.e || (prdata & nt.m) !== (nt.d & nt.m)) fail("apb answer mismatch");
            end
        end
        if (rdr.ph == 4'h8) begin
            if (damping_out === 1'b1) begin
                n_high++;
                if (f_hi < 0) f_hi = n_smp;
            end
            n_smp++;
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic er);
        int i;
        notes.push_back('{d, m, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            fail("no ready");
            complete_run();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] cfg(input logic [3:0] kk, input logic xm, input logic [4:0] md,
                                        input logic otp, input logic [2:0] f);
        return {kk, 4'h0, 6'h01, xm, md, 3'h0, otp, 4'h0, f, 1'b0};
    endfunction : cfg
    // Busy is seen high before low, so a late start cannot pass for an early end
    task automatic tx(input logic [4:0] md, input logic [2:0] f, input int ec, input int eh);
        int  i;
        bit  seen;
        seen = 0;
        apb(1, 8'h00, cfg(4'h9, 1'b1, md, 1'b0, f), 0, 0);
        apb(1, 8'h08, w, 0, 0);
        apb(1, 8'h04, 32'h00000001, 0, 0);
        n_high = 0;
        n_smp = 0;
        f_hi = -1;
        for (i = 0; i < 1000; i++) begin
            apb(0, 8'h0C, 0, 0, 0);
            if (rd[10] === 1'b1) seen = 1;
            else if (seen) break;
        end
        if (i == 1000) begin
            fail("transmit hang");
            complete_run();
        end
        cmp_count++;
        if (n_high != ec) fail("damping count");
        cmp_count++;
        if (eh >= 0 && (f_hi > 2) != (eh == 1)) fail("start marker order");
    endtask : tx
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        n_errors = 0;
        cmp_count = 0;
        f_hi = -1;
        seed = $urandom(32'hDC4AAC72);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0, 32'hFFFFFFFF, 0);
        apb(0, 8'h0C, 32'h00001000, 32'hFFFFFFFF, 0);
        apb(0, 8'h14, 0, 32'hFFFFFFFF, 1);
        apb(1, 8'h20, $urandom, 0, 1);
        for (k = 0; k < 16; k++) begin
            x = $urandom;
            e = x && (k == 6 || k == 9);
            apb(1, 8'h00, cfg(k, x, 5'h00, 1'b0, 3'b111), 0, 0);
            apb(0, 8'h0C, {19'h0, k == 9, e, 11'h0}, {19'h0, e, 1'b1, 11'h0}, 0);
        end
        // ----------------------------------------
        // One-time lock, key 9 then key 6
        // ----------------------------------------
        c = cfg(4'h9, 1'b1, 5'h00, 1'b1, 3'b000);
        apb(1, 8'h00, c, 0, 0);
        apb(1, 8'h00, 32'h0, 0, 0);
        apb(0, 8'h00, c, 32'hFFFFFFFF, 0);
        apb(0, 8'h0C, 32'h00002000, 32'h00006000, 0);
        apb(1, 8'h04, 32'h00000002, 0, 0);
        c = cfg(4'h6, 1'b1, 5'h00, 1'b1, 3'b000);
        apb(1, 8'h00, c, 0, 0);
        apb(0, 8'h00, c, 32'hFFFFFFFF, 0);
        apb(1, 8'h00, 32'h0, 0, 0);
        apb(0, 8'h00, c, 32'hFFFFFFFF, 0);
        apb(0, 8'h0C, 32'h00006000, 32'h00006000, 0);
        apb(0, 8'h04, 0, 32'h00000002, 0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        w = $urandom;
        tx(5'h00, 3'b100, 4 * (1 + $countones(w)), 1);
        w = $urandom;
        tx(5'h00, 3'b100, 4 * (1 + $countones(w)), 0);
        tx(5'h00, 3'b001, 4 * (32 - $countones(w)), -1);
        tx(5'h08, 3'b000, 64, -1);
        w = 32'h00000000;
        tx(5'h04, 3'b000, 52, -1);
        tx(5'h05, 3'b000, 65, -1);
        w = 32'hFFFFFFFF;
        tx(5'h01, 3'b000, 64, -1);
        tx(5'h10, 3'b000, 64, -1);
        // ----------------------------------------
        // Fast write from the reader
        // ----------------------------------------
        apb(1, 8'h00, cfg(4'h9, 1'b1, 5'h00, 1'b0, 3'b010), 0, 0);
        apb(1, 8'h04, 32'h00000004, 0, 0);
        w = $urandom;
        rdr.send(w, 8, 27);
        apb(0, 8'h0C, 32'h00000208, 32'h0000033F, 0);
        rdr.wait_fc(40);
        apb(0, 8'h0C, 32'h00000008, 32'h0000033F, 0);
        apb(0, 8'h10, {24'h0, w[7:0]}, 32'h000000FF, 0);
        rdr.send(32'h00000007, 3, 20);
        rdr.wait_fc(40);
        apb(0, 8'h0C, 32'h00000100, 32'h00000300, 0);
        complete_run();
    end
endmodule : rtec_top_test
`default_nettype wire
